/* common/nav_aid_pkg.sv */
// Constants for the aiding and configuration packet decoder.
// Assumes a 40 MHz bus clock and little-endian payload bytes in each word.
package nav_aid_pkg;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_HZ = 40000000;
    localparam int AIR_HOLD_MS = 1000;
    localparam int AIR_HOLD_CYC = AIR_HOLD_MS * (CLK_HZ / 1000);
    localparam int AIR_CNT_W = 26;

    // ********************************************************
    // Packet identifiers and lengths
    // ********************************************************
    localparam logic [7:0] ID_PITOT = 8'h38;
    localparam logic [7:0] ID_WIND = 8'h39;
    localparam logic [7:0] ID_ODO = 8'h43;
    localparam logic [7:0] ID_AIR = 8'h44;
    localparam logic [7:0] ID_AUTO = 8'h49;
    localparam logic [7:0] ID_TIMER = 8'hB4;
    localparam logic [7:0] LEN_PITOT = 8'h08;
    localparam logic [7:0] LEN_WIND = 8'h0C;
    localparam logic [7:0] LEN_ODO = 8'h0D;
    localparam logic [7:0] LEN_AIR = 8'h19;
    localparam logic [7:0] LEN_AUTO = 8'h18;
    localparam logic [7:0] LEN_TIMER = 8'h04;

    // ********************************************************
    // Register map (byte addresses)
    // ********************************************************
    localparam logic [7:0] ADDR_ID = 8'h00;
    localparam logic [7:0] ADDR_LEN = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_TIMER = 8'h10;
    localparam logic [2:0] PAY_PAGE = 3'h1;
    localparam int PAY_WORDS = 7;
    localparam int CMD_SUBMIT_BIT = 0;
    localparam int ST_ACCEPT_BIT = 0;
    localparam int ST_REJECT_BIT = 1;
    localparam int ST_WIND_STATIC_BIT = 2;
    localparam int ST_WIND_VALID_BIT = 3;
    localparam int TMR_PERSIST_BIT = 0;
    localparam int TMR_UTC_BIT = 8;
    localparam int TMR_PERIOD_LSB = 16;

    // ********************************************************
    // Payload fields
    // ********************************************************
    localparam int ODO_REVERSE_BIT = 0;
    localparam int AIR_ALT_OK_BIT = 0;
    localparam int AIR_SPD_OK_BIT = 1;
    localparam int AIR_REF_RESET_BIT = 2;
    localparam logic [15:0] PERIOD_MIN = 16'h03E8;
    localparam logic [15:0] PERIOD_RESET = 16'h03E8;
    localparam int SECOND_POW2 = 6;
    localparam int SECOND_POW5 = 6;

endpackage

/* logic/nav_aid_decoder.sv */
// Aiding and configuration packet decoder with an AHB-Lite register slave.
// Assumes a single slave on the bus, word transfers only, and framing done upstream.
`timescale 1ns/1ps
`default_nettype none

module nav_aid_decoder #(
    parameter int AIR_HOLD_CYCLES = nav_aid_pkg::AIR_HOLD_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic pitot_gpio_active,
    input wire logic nvm_load,
    input wire logic [15:0] nvm_period,
    input wire logic nvm_utc,
    output logic [31:0] wind_north,
    output logic [31:0] wind_east,
    output logic [31:0] wind_sd,
    output logic wind_est_disable,
    output logic wind_valid,
    output logic wind_strobe,
    output logic [31:0] odo_delay,
    output logic [31:0] odo_speed,
    output logic odo_reverse_ok,
    output logic odo_strobe,
    output logic [31:0] air_alt_delay,
    output logic [31:0] air_spd_delay,
    output logic [31:0] air_alt,
    output logic [31:0] air_spd,
    output logic [31:0] air_alt_sd,
    output logic [31:0] air_spd_sd,
    output logic air_alt_ok,
    output logic air_spd_ok,
    output logic air_ref_reset,
    output logic air_strobe,
    output logic [31:0] auto_dist,
    output logic [31:0] auto_slip,
    output logic [31:0] auto_vx,
    output logic [31:0] auto_vy,
    output logic [31:0] auto_dist_sd,
    output logic auto_strobe,
    output logic [15:0] timer_period,
    output logic timer_utc,
    output logic nvm_commit
);

    // ********************************************************
    // State
    // ********************************************************
    localparam int CW = nav_aid_pkg::AIR_CNT_W;

    typedef struct packed {
        logic [2:0] pit_sync;
        logic pit_level;
        logic [CW-1:0] air_cnt;
        logic dp_write;
        logic dp_read;
        logic [7:0] dp_addr;
        logic [7:0] id;
        logic [7:0] len;
        logic [nav_aid_pkg::PAY_WORDS-1:0][31:0] pay;
        logic go;
        logic acc_flag;
        logic rej_flag;
        logic [31:0] w_north;
        logic [31:0] w_east;
        logic [31:0] w_sd;
        logic w_static;
        logic w_strobe;
        logic [31:0] o_delay;
        logic [31:0] o_speed;
        logic o_rev;
        logic o_strobe;
        logic [31:0] a_alt_delay;
        logic [31:0] a_spd_delay;
        logic [31:0] a_alt;
        logic [31:0] a_spd;
        logic [31:0] a_alt_sd;
        logic [31:0] a_spd_sd;
        logic a_alt_ok;
        logic a_spd_ok;
        logic a_ref_reset;
        logic a_strobe;
        logic [31:0] v_dist;
        logic [31:0] v_slip;
        logic [31:0] v_vx;
        logic [31:0] v_vy;
        logic [31:0] v_dist_sd;
        logic v_strobe;
        logic [15:0] t_period;
        logic t_utc;
        logic t_persist;
        logic t_commit;
    } state_t;

    localparam state_t STATE_RESET = '{t_period: nav_aid_pkg::PERIOD_RESET, default: '0};

    state_t state_reg;
    state_t state_next;

    // Period divides one second when only the allowed powers of two and five remain
    function automatic logic divides_second(input logic [15:0] p);
        logic [15:0] v;
        v = p;
        for (int i = 0; i < nav_aid_pkg::SECOND_POW2; i++) begin
            if (v[0] == 1'b0 && v != 16'h0000) begin
                v = v >> 1;
            end
        end
        for (int i = 0; i < nav_aid_pkg::SECOND_POW5; i++) begin
            if (v % 16'h0005 == 16'h0000 && v != 16'h0000) begin
                v = v / 16'h0005;
            end
        end
        return v == 16'h0001;
    endfunction

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        logic acc;
        logic [7:0] pers;
        logic [7:0] utc;
        logic [15:0] per;
        logic [2:0] widx;
        acc = 1'b0;
        pers = state_reg.pay[0][7:0];
        utc = state_reg.pay[0][15:8];
        per = state_reg.pay[0][31:16];
        widx = state_reg.dp_addr[4:2];
        state_next = state_reg;
        state_next.go = 1'b0;
        state_next.w_strobe = 1'b0;
        state_next.o_strobe = 1'b0;
        state_next.a_strobe = 1'b0;
        state_next.a_ref_reset = 1'b0;
        state_next.v_strobe = 1'b0;
        state_next.t_commit = 1'b0;

        // Pitot pin: level accepted once the last two stages agree
        state_next.pit_sync = {state_reg.pit_sync[1:0], pitot_gpio_active};
        if (state_reg.pit_sync[1] == state_reg.pit_sync[2]) begin
            state_next.pit_level = state_reg.pit_sync[2];
        end
        if (state_reg.air_cnt != '0) begin
            state_next.air_cnt = state_reg.air_cnt - 1'b1;
        end

        // Address phase
        if (hready) begin
            state_next.dp_write = hsel && htrans[1] && hwrite;
            state_next.dp_read = hsel && htrans[1] && !hwrite;
            state_next.dp_addr = haddr[7:0];
        end

        // Data phase writes; flag clears come before decode so a set wins
        if (state_reg.dp_write) begin
            case (state_reg.dp_addr)
                nav_aid_pkg::ADDR_ID: begin
                    state_next.id = hwdata[7:0];
                end
                nav_aid_pkg::ADDR_LEN: begin
                    state_next.len = hwdata[7:0];
                end
                nav_aid_pkg::ADDR_CMD: begin
                    state_next.go = hwdata[nav_aid_pkg::CMD_SUBMIT_BIT];
                end
                nav_aid_pkg::ADDR_STATUS: begin
                    if (hwdata[nav_aid_pkg::ST_ACCEPT_BIT]) begin
                        state_next.acc_flag = 1'b0;
                    end
                    if (hwdata[nav_aid_pkg::ST_REJECT_BIT]) begin
                        state_next.rej_flag = 1'b0;
                    end
                end
                default: begin
                    if (state_reg.dp_addr[7:5] == nav_aid_pkg::PAY_PAGE && widx != 3'h7) begin
                        state_next.pay[widx] = hwdata;
                    end
                end
            endcase
        end

        // Restore of stored timer settings; a packet decoded later wins
        if (nvm_load && nvm_period >= nav_aid_pkg::PERIOD_MIN && (!nvm_utc || divides_second(nvm_period))) begin
            state_next.t_period = nvm_period;
            state_next.t_utc = nvm_utc;
        end

        // Packet decode; reserved words and bits are never looked at
        if (state_reg.go) begin
            case (state_reg.id)
                nav_aid_pkg::ID_WIND: begin
                    if (state_reg.len == nav_aid_pkg::LEN_WIND) begin
                        acc = 1'b1;
                        state_next.w_north = state_reg.pay[0];
                        state_next.w_east = state_reg.pay[1];
                        state_next.w_sd = state_reg.pay[2];
                        state_next.w_static = 1'b1;
                        state_next.w_strobe = 1'b1;
                    end
                end
                nav_aid_pkg::ID_ODO: begin
                    if (state_reg.len == nav_aid_pkg::LEN_ODO) begin
                        acc = 1'b1;
                        state_next.o_delay = state_reg.pay[0];
                        state_next.o_speed = state_reg.pay[1];
                        state_next.o_rev = state_reg.pay[3][nav_aid_pkg::ODO_REVERSE_BIT];
                        state_next.o_strobe = 1'b1;
                    end
                end
                nav_aid_pkg::ID_AIR: begin
                    if (state_reg.len == nav_aid_pkg::LEN_AIR) begin
                        acc = 1'b1;
                        state_next.a_alt_delay = state_reg.pay[0];
                        state_next.a_spd_delay = state_reg.pay[1];
                        state_next.a_alt = state_reg.pay[2];
                        state_next.a_spd = state_reg.pay[3];
                        state_next.a_alt_sd = state_reg.pay[4];
                        state_next.a_spd_sd = state_reg.pay[5];
                        state_next.a_alt_ok = state_reg.pay[6][nav_aid_pkg::AIR_ALT_OK_BIT];
                        state_next.a_spd_ok = state_reg.pay[6][nav_aid_pkg::AIR_SPD_OK_BIT];
                        state_next.a_ref_reset = state_reg.pay[6][nav_aid_pkg::AIR_REF_RESET_BIT];
                        state_next.a_strobe = 1'b1;
                        state_next.air_cnt = CW'(AIR_HOLD_CYCLES);
                    end
                end
                nav_aid_pkg::ID_PITOT: begin
                    if (state_reg.len == nav_aid_pkg::LEN_PITOT) begin
                        acc = 1'b1;
                        state_next.air_cnt = CW'(AIR_HOLD_CYCLES);
                    end
                end
                nav_aid_pkg::ID_AUTO: begin
                    if (state_reg.len == nav_aid_pkg::LEN_AUTO) begin
                        acc = 1'b1;
                        state_next.v_dist = state_reg.pay[0];
                        state_next.v_slip = state_reg.pay[1];
                        state_next.v_vx = state_reg.pay[2];
                        state_next.v_vy = state_reg.pay[3];
                        state_next.v_dist_sd = state_reg.pay[4];
                        state_next.v_strobe = 1'b1;
                    end
                end
                nav_aid_pkg::ID_TIMER: begin
                    // Out-of-range settings leave the running timer untouched
                    if (state_reg.len == nav_aid_pkg::LEN_TIMER && pers <= 8'h01 && utc <= 8'h01
                        && per >= nav_aid_pkg::PERIOD_MIN
                        && (utc == 8'h00 || divides_second(per))) begin
                        acc = 1'b1;
                        state_next.t_period = per;
                        state_next.t_utc = utc[0];
                        state_next.t_persist = pers[0];
                        state_next.t_commit = pers[0];
                    end
                end
                default: begin
                    acc = 1'b0;
                end
            endcase
            if (acc) begin
                state_next.acc_flag = 1'b1;
            end else begin
                state_next.rej_flag = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ********************************************************
    // Bus read and outputs
    // ********************************************************
    always_comb begin
        hrdata = 32'h00000000;
        if (state_reg.dp_read) begin
            case (state_reg.dp_addr)
                nav_aid_pkg::ADDR_ID: hrdata = {24'h000000, state_reg.id};
                nav_aid_pkg::ADDR_LEN: hrdata = {24'h000000, state_reg.len};
                nav_aid_pkg::ADDR_STATUS: begin
                    hrdata[nav_aid_pkg::ST_ACCEPT_BIT] = state_reg.acc_flag;
                    hrdata[nav_aid_pkg::ST_REJECT_BIT] = state_reg.rej_flag;
                    hrdata[nav_aid_pkg::ST_WIND_STATIC_BIT] = state_reg.w_static;
                    hrdata[nav_aid_pkg::ST_WIND_VALID_BIT] = wind_valid;
                end
                nav_aid_pkg::ADDR_TIMER: begin
                    hrdata[nav_aid_pkg::TMR_PERSIST_BIT] = state_reg.t_persist;
                    hrdata[nav_aid_pkg::TMR_UTC_BIT] = state_reg.t_utc;
                    hrdata[nav_aid_pkg::TMR_PERIOD_LSB +: 16] = state_reg.t_period;
                end
                default: begin
                    if (state_reg.dp_addr[7:5] == nav_aid_pkg::PAY_PAGE && state_reg.dp_addr[4:2] != 3'h7) begin
                        hrdata = state_reg.pay[state_reg.dp_addr[4:2]];
                    end
                end
            endcase
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wind_valid = state_reg.air_cnt != '0 || state_reg.pit_level;
    assign wind_north = state_reg.w_north;
    assign wind_east = state_reg.w_east;
    assign wind_sd = state_reg.w_sd;
    assign wind_est_disable = state_reg.w_static;
    assign wind_strobe = state_reg.w_strobe;
    assign odo_delay = state_reg.o_delay;
    assign odo_speed = state_reg.o_speed;
    assign odo_reverse_ok = state_reg.o_rev;
    assign odo_strobe = state_reg.o_strobe;
    assign air_alt_delay = state_reg.a_alt_delay;
    assign air_spd_delay = state_reg.a_spd_delay;
    assign air_alt = state_reg.a_alt;
    assign air_spd = state_reg.a_spd;
    assign air_alt_sd = state_reg.a_alt_sd;
    assign air_spd_sd = state_reg.a_spd_sd;
    assign air_alt_ok = state_reg.a_alt_ok;
    assign air_spd_ok = state_reg.a_spd_ok;
    assign air_ref_reset = state_reg.a_ref_reset;
    assign air_strobe = state_reg.a_strobe;
    assign auto_dist = state_reg.v_dist;
    assign auto_slip = state_reg.v_slip;
    assign auto_vx = state_reg.v_vx;
    assign auto_vy = state_reg.v_vy;
    assign auto_dist_sd = state_reg.v_dist_sd;
    assign auto_strobe = state_reg.v_strobe;
    assign timer_period = state_reg.t_period;
    assign timer_utc = state_reg.t_utc;
    assign nvm_commit = state_reg.t_commit;

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence wind_pkt_s;
        state_reg.go && state_reg.id == nav_aid_pkg::ID_WIND && state_reg.len == nav_aid_pkg::LEN_WIND;
    endsequence
    sequence air_pkt_s;
        state_reg.go && state_reg.id == nav_aid_pkg::ID_AIR && state_reg.len == nav_aid_pkg::LEN_AIR;
    endsequence

    wind_capture_a: assert property (wind_pkt_s |=> wind_est_disable && wind_strobe
        && wind_east == $past(state_reg.pay[1])) else $error("wind packet not captured");
    wind_hold_a: assert property (wind_est_disable |=> wind_est_disable)
        else $error("wind estimation re-enabled");
    wind_valid_a: assert property (air_pkt_s |=> wind_valid [*3])
        else $error("wind not valid after air data");
    odo_flag_a: assert property (state_reg.go && state_reg.id == nav_aid_pkg::ID_ODO
        && state_reg.len == nav_aid_pkg::LEN_ODO |=> odo_strobe && odo_reverse_ok == $past(state_reg.pay[3][0]))
        else $error("odometer flag wrong");
    air_flags_a: assert property (air_pkt_s |=> air_spd_ok == $past(state_reg.pay[6][1])
        && air_ref_reset == $past(state_reg.pay[6][2]) ##1 !air_ref_reset) else $error("air flags wrong");
    len_reject_a: assert property (state_reg.go && state_reg.id == nav_aid_pkg::ID_WIND
        && state_reg.len != nav_aid_pkg::LEN_WIND |=> state_reg.rej_flag && !wind_strobe)
        else $error("bad length not rejected");
    timer_keep_a: assert property (state_reg.go && state_reg.id == nav_aid_pkg::ID_TIMER
        && state_reg.pay[0][31:16] < nav_aid_pkg::PERIOD_MIN && !nvm_load |=> $stable(timer_period))
        else $error("short period accepted");
    timer_range_a: assert property (timer_period >= nav_aid_pkg::PERIOD_MIN)
        else $error("timer period below minimum");
    utc_div_a: assert property (timer_utc |-> divides_second(timer_period))
        else $error("aligned period does not divide a second");
    commit_a: assert property (nvm_commit |-> state_reg.t_persist ##1 !nvm_commit)
        else $error("commit without persistence");
    readback_a: assert property (state_reg.dp_read && state_reg.dp_addr == nav_aid_pkg::ADDR_TIMER
        |-> hrdata[31:16] == timer_period) else $error("timer readback wrong");

endmodule // nav_aid_decoder

`default_nettype wire

/* verif/ahb_host.sv */
// Host model: AHB-Lite master that writes packet registers and reads them back.
// Assumes one zero-wait slave whose hreadyout is looped back as hready.
`timescale 1ns/1ps
`default_nettype none
module ahb_host (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        // Stale data must not look valid
        hwdata <= ~d;
    endtask
endmodule // ahb_host
`default_nettype wire

/* verif/nav_aiding_config_packet_decoder_test.sv */
// Testbench: packet table, then air data, pin, load and reset cases.
// Assumes the host model drives the bus; air hold shortened to 20 cycles.
`timescale 1ns/1ps
`default_nettype none
module nav_aiding_config_packet_decoder_test;
    localparam int HOLD = 20;
    typedef struct packed {logic [7:0] id; logic [7:0] len; logic [31:0] w0; logic acc; logic [4:0] strb;} row_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic pitot_gpio_active = 1'b0;
    logic nvm_load = 1'b0;
    logic [15:0] nvm_period = 16'h0000;
    logic nvm_utc = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, wind_strobe, odo_strobe, air_strobe, auto_strobe, nvm_commit;
    logic wind_est_disable, wind_valid, odo_reverse_ok, air_alt_ok, air_spd_ok, air_ref_reset, timer_utc;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] timer_period;
    logic [31:0] haddr, hwdata, hrdata, q, wind_north, odo_delay, air_alt_delay, auto_dist;
    logic [31:0] wind_east, wind_sd, odo_speed, air_spd_delay, air_alt, air_spd, air_alt_sd, air_spd_sd;
    logic [31:0] auto_slip, auto_vx, auto_vy, auto_dist_sd;
    logic [31:0] last [logic [7:0]];
    int mismatches = 0;
    int n_checks = 0;
    row_t rows [12];
    always #12.5 hclk = ~hclk;
    ahb_host host_i (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
    nav_aid_decoder #(.AIR_HOLD_CYCLES(HOLD)) nav_aid_decoder_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pitot_gpio_active,
        .nvm_load, .nvm_period, .nvm_utc, .wind_north, .wind_east, .wind_sd, .wind_est_disable,
        .wind_valid, .wind_strobe, .odo_delay, .odo_speed, .odo_reverse_ok, .odo_strobe, .air_alt_delay,
        .air_spd_delay, .air_alt, .air_spd, .air_alt_sd, .air_spd_sd, .air_alt_ok, .air_spd_ok,
        .air_ref_reset, .air_strobe, .auto_dist, .auto_slip, .auto_vx, .auto_vy, .auto_dist_sd,
        .auto_strobe, .timer_period, .timer_utc, .nvm_commit);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Returns in the cycle the strobes stand
    task automatic send(input logic [7:0] id, input logic [7:0] len, input logic [31:0] w0, input logic [7:0] flg);
        host_i.xfer(1'b1, 8'h00, {24'h0, id}, q);
        host_i.xfer(1'b1, 8'h04, {24'h0, len}, q);
        host_i.xfer(1'b1, 8'h20, w0, q);
        for (int k = 1; k < 7; k++) host_i.xfer(1'b1, 8'h20 + 8'(4 * k), {8'hA0 + 8'(k), 16'h0, flg}, q);
        host_i.xfer(1'b1, 8'h08, 32'h1, q);
        @(posedge hclk);
        #1;
    endtask
    function automatic logic [31:0] ff(input logic [7:0] id);
        case (id)
            8'h39: return wind_north;
            8'h43: return odo_delay;
            8'h44: return air_alt_delay;
            8'h49: return auto_dist;
            8'hB4: return {timer_period, 7'h0, timer_utc, 8'h0};
            default: return 32'h0;
        endcase
    endfunction
    initial begin
        #(25 * 20000);
        mismatches++;
        end_sim();
    end
    initial begin
        rows = '{'{8'h39, 8'h0C, 32'h4120_0000, 1'b1, 5'h10}, '{8'h39, 8'h0D, 32'h0BAD_0000, 1'b0, 5'h00},
            '{8'h43, 8'h0D, 32'h3F80_0000, 1'b1, 5'h08}, '{8'h43, 8'h0C, 32'h1111_0000, 1'b0, 5'h00},
            '{8'h44, 8'h19, 32'h4000_0000, 1'b1, 5'h04}, '{8'h49, 8'h18, 32'h4040_0000, 1'b1, 5'h02},
            '{8'h49, 8'h19, 32'h2222_0000, 1'b0, 5'h00}, '{8'h3A, 8'h10, 32'h3333_0000, 1'b0, 5'h00},
            '{8'hB4, 8'h04, 32'h2710_0101, 1'b1, 5'h01}, '{8'hB4, 8'h04, 32'h3A98_0100, 1'b0, 5'h00},
            '{8'hB4, 8'h04, 32'h03E7_0000, 1'b0, 5'h00}, '{8'hB4, 8'h04, 32'hFFFF_0000, 1'b1, 5'h00}};
        last[8'hB4] = 32'h03E8_0000;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            host_i.xfer(1'b1, 8'h0C, 32'h3, q);
            send(rows[i].id, rows[i].len, rows[i].w0, 8'hF8);
            chk({wind_strobe, odo_strobe, air_strobe, auto_strobe, nvm_commit}, rows[i].strb);
            if (rows[i].acc) last[rows[i].id] = rows[i].w0;
            host_i.xfer(1'b0, 8'h0C, 32'h0, q);
            chk(q[1:0], {!rows[i].acc, rows[i].acc});
            host_i.xfer(1'b0, 8'h10, 32'h0, q);
            chk(q, last[8'hB4]);
            chk(ff(rows[i].id), last.exists(rows[i].id) ? last[rows[i].id] & 32'hFFFF_FF00 : 32'h0);
        end
        chk(wind_est_disable, 1'b1);
        chk(odo_reverse_ok, 1'b0);
        chk(wind_valid, 1'b0);
        // Payload words 1..6 carry A0+k in the top byte and the flag byte at the bottom
        chk(wind_east, 32'hA100_00F8);
        chk(wind_sd, 32'hA200_00F8);
        chk(odo_speed, 32'hA100_00F8);
        chk(air_spd_delay, 32'hA100_00F8);
        chk(air_alt, 32'hA200_00F8);
        chk(air_spd, 32'hA300_00F8);
        chk(air_alt_sd, 32'hA400_00F8);
        chk(air_spd_sd, 32'hA500_00F8);
        chk(auto_slip, 32'hA100_00F8);
        chk(auto_vx, 32'hA200_00F8);
        chk(auto_vy, 32'hA300_00F8);
        chk(auto_dist_sd, 32'hA400_00F8);
        send(8'h43, 8'h0D, 32'h0, 8'h01);
        chk({odo_strobe, odo_reverse_ok}, 2'h3);
        // Datum changed, so the reference reset goes out with this packet
        send(8'h44, 8'h19, 32'h0, 8'h07);
        chk({air_strobe, air_ref_reset, air_alt_ok, air_spd_ok, wind_valid}, 5'h1F);
        repeat (HOLD - 4) @(posedge hclk);
        #1;
        chk({air_ref_reset, wind_valid}, 2'h1);
        repeat (6) @(posedge hclk);
        #1;
        chk(wind_valid, 1'b0);
        send(8'h38, 8'h08, 32'h0, 8'hF8);
        chk(wind_valid, 1'b1);
        repeat (HOLD) @(posedge hclk);
        #1;
        chk(wind_valid, 1'b0);
        @(posedge hclk);
        pitot_gpio_active <= 1'b1;
        repeat (5) @(posedge hclk);
        #1;
        chk(wind_valid, 1'b1);
        host_i.xfer(1'b1, 8'h3C, 32'hFFFF_FFFF, q);
        host_i.xfer(1'b0, 8'h3C, 32'h0, q);
        chk(q, 32'h0);
        chk(hresp, 1'b0);
        nvm_period <= 16'h07D0;
        nvm_load <= 1'b1;
        @(posedge hclk);
        nvm_load <= 1'b0;
        @(posedge hclk);
        #1;
        chk(timer_period, 16'h07D0);
        // Aligned restore with a period that does not divide a second is ignored
        @(posedge hclk);
        nvm_period <= 16'h0BB8;
        nvm_utc <= 1'b1;
        nvm_load <= 1'b1;
        @(posedge hclk);
        nvm_load <= 1'b0;
        @(posedge hclk);
        #1;
        chk({timer_period, timer_utc}, {16'h07D0, 1'b0});
        @(posedge hclk);
        nvm_period <= 16'h1388;
        nvm_load <= 1'b1;
        @(posedge hclk);
        nvm_load <= 1'b0;
        @(posedge hclk);
        #1;
        chk({timer_period, timer_utc}, {16'h1388, 1'b1});
        @(posedge hclk);
        hresetn <= 1'b0;
        pitot_gpio_active <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        chk({timer_period, timer_utc, wind_est_disable, wind_valid}, 19'h03E8 << 3);
        end_sim();
    end
endmodule // nav_aiding_config_packet_decoder_test
`default_nettype wire
